// >>> verilog/host_xfer_pkg.sv
// How it works
// [R1] Burst bit set: back-to-back CAS cycles
// [R2] Fast bit low: three clocks per CAS
// [R3] Fast bit set: two clocks per CAS; the code gives two clocks only when the burst bit is also set, else three
// [R4] Direction bit: low reads buffer, high writes
// [R5] Dual bit low: one block per frame
// [R6] Block runs start through end, inclusive
// [R7] Single mode: next frame, same offsets
// [R8] Dual mode: A then B, then frame advance
// [R9] Reset points both pair pointers at A
// [R10] Dual mode high-byte write toggles pointer
// [R11] Mode read shows both pointer states
// [R12] Mode write with bit low clears pointer
// [R13] Frame counter wraps to start after last
// [R14] Software repositions frame via start frame
// [R15] Current frame readable, eleven bits, two bytes
// [R16] Offsets twelve bits: low byte, high nibble
// [R17] Live offset counter readable and writable
// [R18] Start frame eleven bits over two bytes
// [R19] Start frame write acts immediately
// [R20] Software writes mode register first
// [R21] Software writes A start offset last
// [R22] Dual mode readback sees the other pair
// [R23] Wrap frame register, eleven bits, read/write
// [R24] Counter loads start, steps per byte
// [R25] Burst bit low: single-byte accesses
`default_nettype none
package host_xfer_pkg;
  localparam int ADDR_W = 18;
  localparam int OFFS_W = 12;
  localparam int FRAME_W = 11;
  localparam int IDX_W = 16;
  // Register indices; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_LIVE_LO = 16'hf09c;
  localparam logic [IDX_W-1:0] IDX_LIVE_HI = 16'hf09d;
  localparam logic [IDX_W-1:0] IDX_MODE = 16'hf0e2;
  localparam logic [IDX_W-1:0] IDX_SOFF_LO = 16'hf0e8;
  localparam logic [IDX_W-1:0] IDX_SOFF_HI = 16'hf0e9;
  localparam logic [IDX_W-1:0] IDX_EOFF_LO = 16'hf0ea;
  localparam logic [IDX_W-1:0] IDX_EOFF_HI = 16'hf0eb;
  localparam logic [IDX_W-1:0] IDX_SFRM_LO = 16'hf0ec;
  localparam logic [IDX_W-1:0] IDX_SFRM_HI = 16'hf0ed;
  localparam logic [IDX_W-1:0] IDX_CFRM_LO = 16'hf0ee;
  localparam logic [IDX_W-1:0] IDX_CFRM_HI = 16'hf0ef;
  localparam logic [IDX_W-1:0] IDX_WRAP_LO = 16'hf0f2;
  localparam logic [IDX_W-1:0] IDX_WRAP_HI = 16'hf0f3;
  // Mode register fields
  localparam int MODE_BURST = 0;
  localparam int MODE_FAST = 1;
  localparam int MODE_DIR = 2;
  localparam int MODE_DUAL = 3;
  localparam int MODE_SPTR = 4;
  localparam int MODE_EPTR = 5;
  localparam int MODE_RUN = 6;
  localparam int MODE_BUSY = 7;
  localparam logic [7:0] MODE_WR_MASK = 8'h4f;
  localparam logic [7:0] MODE_RESET = 8'h00;
  // CAS cycle lengths in clocks
  localparam logic [1:0] CAS_SLOW = 2'h3;
  localparam logic [1:0] CAS_FAST = 2'h2;
  localparam logic [OFFS_W-1:0] OFFS_RESET = 12'h000;
  localparam logic [FRAME_W-1:0] FRAME_RESET = 11'h000;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_LOAD = 2'b01,
    ST_CAS = 2'b10,
    ST_GAP = 2'b11
  } xfer_state_e;
endpackage
`default_nettype wire

// >>> verilog/host_xfer_addr.sv
`timescale 1ns/100ps
`default_nettype none
module host_xfer_addr (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [host_xfer_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic host_ready,
  output logic xfer_ack,
  output logic dram_cas_n,
  output logic dram_write,
  output logic dram_burst,
  output logic [host_xfer_pkg::FRAME_W-1:0] dram_frame,
  output logic [host_xfer_pkg::OFFS_W-1:0] dram_offset,
  output logic xfer_busy
);
  import host_xfer_pkg::*;

  function automatic logic [7:0] byte_of(input logic [15:0] v, input logic hi);
    byte_of = hi ? v[15:8] : v[7:0];
  endfunction

  function automatic logic [15:0] put_byte(input logic [15:0] v, input logic hi, input logic [7:0] b);
    put_byte = hi ? {b, v[7:0]} : {v[15:8], b};
  endfunction

  // Configuration state
  logic [7:0] mode_q, mode_d;
  logic start_ptr_q, start_ptr_d;
  logic end_ptr_q, end_ptr_d;
  logic [OFFS_W-1:0] soff_q [2];
  logic [OFFS_W-1:0] soff_d [2];
  logic [OFFS_W-1:0] eoff_q [2];
  logic [OFFS_W-1:0] eoff_d [2];
  logic [FRAME_W-1:0] sfrm_q, sfrm_d;
  logic [FRAME_W-1:0] wrap_q, wrap_d;
  // Engine state
  xfer_state_e state_q, state_d;
  logic [1:0] cas_cnt_q, cas_cnt_d;
  logic pair_b_q, pair_b_d;
  logic [OFFS_W-1:0] live_q, live_d;
  logic [FRAME_W-1:0] cfrm_q, cfrm_d;

  logic wr_en;
  logic [IDX_W-1:0] idx;
  logic [7:0] wb;
  logic mapped;
  logic sfrm_hi_wr;
  logic [1:0] cas_len;
  logic last_clk;
  logic at_end;

  assign wr_en = psel & penable & pwrite;
  assign idx = paddr[ADDR_W-1:2];
  assign wb = pwdata[7:0];
  assign pready = 1'b1;
  assign sfrm_hi_wr = wr_en & (idx == IDX_SFRM_HI);

  always_comb begin
    mapped = (paddr[1:0] == 2'b00);
    unique case (idx)
      IDX_LIVE_LO, IDX_LIVE_HI, IDX_MODE, IDX_SOFF_LO, IDX_SOFF_HI, IDX_EOFF_LO, IDX_EOFF_HI,
      IDX_SFRM_LO, IDX_SFRM_HI, IDX_CFRM_LO, IDX_CFRM_HI, IDX_WRAP_LO, IDX_WRAP_HI: ;
      default: mapped = 1'b0;
    endcase
  end

  assign pslverr = psel & penable & ~mapped;

  always_comb begin
    logic [7:0] r;
    r = 8'h00;
    unique case (idx)
      IDX_LIVE_LO, IDX_LIVE_HI: r = byte_of({4'h0, live_q}, idx[0]); // see [R17]
      IDX_MODE: begin
        r = mode_q;
        r[MODE_SPTR] = start_ptr_q; // see [R11]
        r[MODE_EPTR] = end_ptr_q; // see [R11]
        r[MODE_BUSY] = (state_q != ST_IDLE);
      end
      IDX_SOFF_LO, IDX_SOFF_HI: r = byte_of({4'h0, soff_q[start_ptr_q]}, idx[0]); // see [R22]
      IDX_EOFF_LO, IDX_EOFF_HI: r = byte_of({4'h0, eoff_q[end_ptr_q]}, idx[0]); // see [R22]
      IDX_SFRM_LO, IDX_SFRM_HI: r = byte_of({5'h00, sfrm_q}, idx[0]);
      IDX_CFRM_LO, IDX_CFRM_HI: r = byte_of({5'h00, cfrm_q}, idx[0]); // see [R15]
      IDX_WRAP_LO, IDX_WRAP_HI: r = byte_of({5'h00, wrap_q}, idx[0]); // see [R23]
      default: r = 8'h00;
    endcase
    prdata = (psel & ~pwrite & mapped) ? {24'h00_0000, r} : 32'h0000_0000;
  end

  // Configuration registers
  always_comb begin
    logic [15:0] t;
    t = 16'h0000;
    mode_d = mode_q;
    start_ptr_d = start_ptr_q;
    end_ptr_d = end_ptr_q;
    soff_d = soff_q;
    eoff_d = eoff_q;
    sfrm_d = sfrm_q;
    wrap_d = wrap_q;
    if (wr_en) begin
      unique case (idx)
        IDX_MODE: begin
          mode_d = wb & MODE_WR_MASK;
          if (!wb[MODE_SPTR]) begin
            start_ptr_d = 1'b0; // see [R12]
          end
          if (!wb[MODE_EPTR]) begin
            end_ptr_d = 1'b0; // see [R12]
          end
        end
        IDX_SOFF_LO, IDX_SOFF_HI: begin
          t = put_byte({4'h0, soff_q[start_ptr_q]}, idx[0], wb);
          soff_d[start_ptr_q] = t[OFFS_W-1:0]; // see [R16]
          if (idx[0] && mode_q[MODE_DUAL]) begin
            start_ptr_d = ~start_ptr_q; // see [R10]
          end
        end
        IDX_EOFF_LO, IDX_EOFF_HI: begin
          t = put_byte({4'h0, eoff_q[end_ptr_q]}, idx[0], wb);
          eoff_d[end_ptr_q] = t[OFFS_W-1:0]; // see [R16]
          if (idx[0] && mode_q[MODE_DUAL]) begin
            end_ptr_d = ~end_ptr_q; // see [R10]
          end
        end
        IDX_SFRM_LO, IDX_SFRM_HI: begin
          t = put_byte({5'h00, sfrm_q}, idx[0], wb);
          sfrm_d = t[FRAME_W-1:0]; // see [R18]
        end
        IDX_WRAP_LO, IDX_WRAP_HI: begin
          t = put_byte({5'h00, wrap_q}, idx[0], wb);
          wrap_d = t[FRAME_W-1:0]; // see [R23]
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q <= MODE_RESET;
      start_ptr_q <= 1'b0; // see [R9]
      end_ptr_q <= 1'b0; // see [R9]
      soff_q[0] <= OFFS_RESET;
      soff_q[1] <= OFFS_RESET;
      eoff_q[0] <= OFFS_RESET;
      eoff_q[1] <= OFFS_RESET;
      sfrm_q <= FRAME_RESET;
      wrap_q <= FRAME_RESET;
    end else begin
      mode_q <= mode_d;
      start_ptr_q <= start_ptr_d;
      end_ptr_q <= end_ptr_d;
      soff_q <= soff_d;
      eoff_q <= eoff_d;
      sfrm_q <= sfrm_d;
      wrap_q <= wrap_d;
    end
  end

  // Transfer engine
  always_comb begin
    if (mode_q[MODE_BURST] && mode_q[MODE_FAST]) begin
      cas_len = CAS_FAST; // see [R3]
    end else begin
      cas_len = CAS_SLOW; // see [R2]
    end
  end

  assign last_clk = (state_q == ST_CAS) && (cas_cnt_q == cas_len - 2'd1);
  assign at_end = (live_q == eoff_q[pair_b_q]);

  always_comb begin
    logic [15:0] lw;
    lw = put_byte({4'h0, live_q}, idx[0], wb);
    state_d = state_q;
    cas_cnt_d = cas_cnt_q;
    pair_b_d = pair_b_q;
    live_d = live_q;
    cfrm_d = cfrm_q;
    unique case (state_q)
      ST_IDLE: begin
        pair_b_d = 1'b0;
        if (mode_q[MODE_RUN]) begin
          state_d = ST_LOAD;
        end
      end
      ST_LOAD: begin
        live_d = soff_q[pair_b_q]; // see [R24]
        cas_cnt_d = 2'd0;
        state_d = ST_GAP;
      end
      ST_CAS: begin
        cas_cnt_d = cas_cnt_q + 2'd1;
        if (last_clk) begin
          cas_cnt_d = 2'd0;
          if (at_end) begin
            // End address done too; block is complete
            if (mode_q[MODE_DUAL] && !pair_b_q) begin
              pair_b_d = 1'b1; // see [R8]
            end else begin
              pair_b_d = 1'b0; // see [R5]
              // Next frame with the same offsets
              cfrm_d = (cfrm_q == wrap_q) ? sfrm_q : cfrm_q + 11'd1; // see [R7] [R13]
            end
            state_d = mode_q[MODE_RUN] ? ST_LOAD : ST_IDLE;
          end else begin
            live_d = live_q + 12'd1; // see [R6] [R24]
            if (!(mode_q[MODE_BURST] && host_ready && mode_q[MODE_RUN])) begin
              state_d = ST_GAP; // see [R25]
            end
          end
        end
      end
      ST_GAP: begin
        if (!mode_q[MODE_RUN]) begin
          state_d = ST_IDLE;
        end else if (host_ready) begin
          state_d = ST_CAS; // see [R1]
        end
      end
      default: state_d = ST_IDLE;
    endcase
    if (wr_en && (idx == IDX_LIVE_LO || idx == IDX_LIVE_HI)) begin
      live_d = lw[OFFS_W-1:0]; // see [R17]
    end
    if (wr_en && idx == IDX_SOFF_HI && !start_ptr_q && state_q == ST_IDLE) begin
      live_d = {wb[3:0], soff_q[0][7:0]}; // see [R21]
    end
    if (sfrm_hi_wr) begin
      cfrm_d = {wb[2:0], sfrm_q[7:0]}; // see [R14] [R19]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= ST_IDLE;
      cas_cnt_q <= 2'd0;
      pair_b_q <= 1'b0;
      live_q <= OFFS_RESET;
      cfrm_q <= FRAME_RESET;
    end else begin
      state_q <= state_d;
      cas_cnt_q <= cas_cnt_d;
      pair_b_q <= pair_b_d;
      live_q <= live_d;
      cfrm_q <= cfrm_d;
    end
  end

  assign xfer_ack = last_clk;
  assign dram_cas_n = (state_q != ST_CAS);
  assign dram_write = mode_q[MODE_DIR]; // see [R4]
  assign dram_burst = mode_q[MODE_BURST];
  assign dram_frame = cfrm_q;
  assign dram_offset = live_q;
  assign xfer_busy = (state_q != ST_IDLE);
endmodule // host_xfer_addr
`default_nettype wire

// >>> dv/host_xfer_addr_checker.sv
`timescale 1ns/100ps
`default_nettype none
module host_xfer_addr_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [host_xfer_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  input wire logic xfer_ack,
  input wire logic dram_cas_n,
  input wire logic dram_burst,
  input wire logic [host_xfer_pkg::FRAME_W-1:0] dram_frame,
  input wire logic [host_xfer_pkg::OFFS_W-1:0] dram_offset,
  input wire logic xfer_busy
);
  import host_xfer_pkg::*;
  logic wr_on;
  logic mode_wr;
  logic fast_q;
  assign wr_on = psel && penable && pwrite;
  assign mode_wr = wr_on && paddr == {IDX_MODE, 2'b00};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fast_q <= 1'b0;
    end else if (mode_wr) begin
      fast_q <= pwdata[MODE_FAST];
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence cas_start;
    !dram_cas_n && ($past(dram_cas_n) || $past(xfer_ack));
  endsequence
  a_cas_length: assert property (cas_start |->
    if (fast_q && dram_burst) (!xfer_ack ##1 xfer_ack) else (!xfer_ack [*2] ##1 xfer_ack))
    else $error("cas length");
  a_single_gap: assert property (xfer_ack && !dram_burst |=> dram_cas_n)
    else $error("single gap");
  a_burst_follow: assert property (mode_wr |=> dram_burst == $past(pwdata[MODE_BURST]))
    else $error("burst bit");
  a_cas_busy: assert property (!dram_cas_n |-> xfer_busy)
    else $error("cas idle");
  a_offset_hold: assert property (!dram_cas_n && !xfer_ack && !wr_on |=> $stable(dram_offset))
    else $error("offset moved");
  a_offset_step: assert property (xfer_ack ##1 !dram_cas_n |-> dram_offset == $past(dram_offset) + 12'h001)
    else $error("offset step");
  a_err_zero: assert property (pslverr |-> prdata == 32'h0000_0000)
    else $error("error read");
  a_frame_idle: assert property (!xfer_busy && !wr_on |=> $stable(dram_frame))
    else $error("frame moved");
  c_fast: cover property (fast_q && dram_burst && xfer_ack);
  c_single: cover property (xfer_ack && !dram_burst);
  c_err: cover property (pslverr);
endmodule // host_xfer_addr_checker
bind host_xfer_addr host_xfer_addr_checker chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
  .prdata, .pslverr, .xfer_ack, .dram_cas_n, .dram_burst, .dram_frame, .dram_offset, .xfer_busy);
`default_nettype wire

// >>> dv/host_port_model.sv
`timescale 1ns/100ps
`default_nettype none
module host_port_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic slow,
  input wire logic clr,
  input wire logic xfer_ack,
  input wire logic [host_xfer_pkg::OFFS_W-1:0] dram_offset,
  input wire logic [host_xfer_pkg::FRAME_W-1:0] dram_frame,
  output logic host_ready
);
  import host_xfer_pkg::*;
  logic [OFFS_W-1:0] off_log [8];
  logic [FRAME_W-1:0] frm_log [8];
  int n;
  logic tick_q;
  // Slow host moves a byte only every other clock
  assign host_ready = slow ? tick_q : 1'b1;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_q <= 1'b0;
      n <= 0;
    end else begin
      tick_q <= ~tick_q;
      if (clr) begin
        n <= 0;
      end else if (xfer_ack && n < 8) begin
        off_log[n] <= dram_offset;
        frm_log[n] <= dram_frame;
        n <= n + 1;
      end
    end
  end
endmodule // host_port_model
`default_nettype wire

// >>> dv/host_xfer_addr_tb.sv
`timescale 1ns/100ps
`default_nettype none
module host_xfer_addr_tb;
  import host_xfer_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic slow = 1'b0;
  logic clr = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic pready, pslverr, host_ready, xfer_ack, dram_cas_n, dram_write, dram_burst, xfer_busy;
  logic [FRAME_W-1:0] dram_frame;
  logic [OFFS_W-1:0] dram_offset;
  logic [7:0] rdat;
  logic rerr;
  int mismatches = 0;
  int cmp_count = 0;
  host_xfer_addr uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .host_ready, .xfer_ack, .dram_cas_n, .dram_write, .dram_burst, .dram_frame, .dram_offset, .xfer_busy);
  host_port_model port (.pclk, .presetn, .slow, .clr, .xfer_ack, .dram_offset, .dram_frame, .host_ready);
  initial begin
    forever #12.5 pclk = ~pclk;
  end
  task check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task apb(input logic w, input logic [IDX_W-1:0] idx, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h00_0000, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdat = prdata[7:0];
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr(input logic [IDX_W-1:0] idx, input logic [7:0] d);
    apb(1'b1, idx, d);
  endtask
  task wr2(input logic [IDX_W-1:0] idx, input logic [7:0] lo, input logic [7:0] hi);
    apb(1'b1, idx, lo);
    apb(1'b1, idx + 16'h0001, hi);
  endtask
  task rd(input logic [IDX_W-1:0] idx, input logic [7:0] exp, input string name);
    apb(1'b0, idx, 8'h00);
    check(name, rdat, exp);
  endtask
  task t_regs;
    rd(IDX_MODE, MODE_RESET, "mode");
    apb(1'b0, 16'h0001, 8'h00);
    check("err", rerr, 1'b1);
    wr2(IDX_WRAP_LO, 8'ha5, 8'hff);
    rd(IDX_WRAP_HI, 8'h07, "wrap_hi");
    wr2(IDX_SFRM_LO, 8'h3c, 8'h05);
    wr(IDX_CFRM_LO, 8'h00);
    rd(IDX_CFRM_LO, 8'h3c, "cur_lo");
    check("frame", dram_frame, 11'h53c);
    wr(IDX_LIVE_HI, 8'hfa);
    rd(IDX_LIVE_HI, 8'h0a, "live_hi");
  endtask
  task t_pointers;
    wr(IDX_MODE, 8'h08);
    wr2(IDX_SOFF_LO, 8'h10, 8'h01);
    rd(IDX_MODE, 8'h18, "ptr_s");
    rd(IDX_SOFF_LO, 8'h00, "pair_b");
    wr(IDX_EOFF_HI, 8'h00);
    rd(IDX_MODE, 8'h38, "ptr_e");
    wr(IDX_MODE, 8'h28);
    rd(IDX_MODE, 8'h28, "ptr_clr");
  endtask
  task collect(input logic [7:0] run_m, input logic [7:0] stop_m, input logic [11:0] oa, input logic [11:0] ob);
    wr2(IDX_SFRM_LO, 8'h02, 8'h00);
    clr <= 1'b1;
    @(posedge pclk);
    clr <= 1'b0;
    wr(IDX_MODE, run_m);
    for (int i = 0; i < 400 && port.n < 6; i++) @(posedge pclk);
    check("dir", dram_write, run_m[MODE_DIR]);
    wr(IDX_MODE, stop_m);
    for (int i = 0; i < 100 && xfer_busy !== 1'b0; i++) @(posedge pclk);
    check("idle", xfer_busy, 1'b0);
    for (int i = 0; i < 6; i++) begin
      check("off", port.off_log[i], i % 2 ? ob : oa);
      check("frm", port.frm_log[i], i % 4 < 2 ? 11'h002 : 11'h003);
    end
  endtask
  task t_burst;
    wr(IDX_MODE, 8'h05);
    wr2(IDX_SOFF_LO, 8'h05, 8'h00);
    wr2(IDX_EOFF_LO, 8'h06, 8'h00);
    wr2(IDX_WRAP_LO, 8'h03, 8'h00);
    collect(8'h45, 8'h05, 12'h005, 12'h006);
  endtask
  task t_byte;
    slow <= 1'b1;
    collect(8'h40, 8'h00, 12'h005, 12'h006);
    slow <= 1'b0;
  endtask
  task t_dual;
    wr(IDX_MODE, 8'h0b);
    wr2(IDX_EOFF_LO, 8'h05, 8'h00);
    wr2(IDX_EOFF_LO, 8'h09, 8'h00);
    wr2(IDX_SOFF_LO, 8'h05, 8'h00);
    wr2(IDX_SOFF_LO, 8'h09, 8'h00);
    wr2(IDX_SOFF_LO, 8'h05, 8'h00);
    collect(8'h4b, 8'h0b, 12'h005, 12'h009);
  endtask
  task print_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    #(25 * 20000);
    mismatches++;
    print_verdict();
  end
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_pointers();
    t_burst();
    t_byte();
    t_dual();
    print_verdict();
  end
endmodule // host_xfer_addr_tb
`default_nettype wire
